// ### core/hsf_map.svh
// Constants for the serial stream formatter
`ifndef HSF_MAP_SVH
`define HSF_MAP_SVH
`define HSF_WORD_W 10
`define HSF_CRC_W 18
`define HSF_CRC_POLY 18'h00031
`define HSF_SCR_W 9
`define HSF_LUMA_BLANK 10'h040
`define HSF_CHROMA_BLANK 10'h200
`define HSF_ACTIVE_LUMA 1920
`define HSF_HINT_WORDS 268
`define HSF_TRS_ONES 10'h3ff
`define HSF_TRS_ZERO 10'h000
`define HSF_TRS_FIXED 10'h200
`define HSF_LN_LO_POS 2
`endif

// ### core/hsf_pkg.sv
// Types for the serial stream formatter
`default_nettype none
package hsf_pkg;
  typedef logic [9:0] hsf_word_t;
  typedef logic [17:0] hsf_crc_t;
  typedef logic [10:0] hsf_line_t;
  typedef enum logic [3:0] {
    HSF_ST_ACTIVE,
    HSF_ST_EAV,
    HSF_ST_LN0,
    HSF_ST_LN1,
    HSF_ST_CRC0,
    HSF_ST_CRC1,
    HSF_ST_HINT,
    HSF_ST_SAV
  } hsf_phase_t;
endpackage
`default_nettype wire

// ### core/hsf_skid.sv
// Two-entry buffer between the word builder and the serializer
`timescale 1ns/10ps
`default_nettype none
module hsf_skid #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];

  // Pointer and occupancy update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

// ### core/hsf_formatter.sv
// Serial stream formatter: framing, check codes, mux, serializer, scrambler
`timescale 1ns/10ps
`default_nettype none
`include "hsf_map.svh"
module hsf_formatter
  import hsf_pkg::*;
#(
  parameter int ACTIVE_LUMA = `HSF_ACTIVE_LUMA,
  parameter int HINT_WORDS = `HSF_HINT_WORDS
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Video source, one luma and one chroma word per accepted beat
  input wire hsf_pkg::hsf_word_t LUMA_IN,
  input wire hsf_pkg::hsf_word_t CHROMA_IN,
  input wire logic [1:0] FLAGS_IN,
  input wire hsf_pkg::hsf_line_t LINE_IN,
  output logic SRC_READY,
  // Serial line
  output logic SER_OUT,
  output logic SER_BIT_EN
);
  import hsf_pkg::*;

  // Check-code step over one ten-bit word, first bit is the LSB
  function automatic hsf_crc_t crc_step(hsf_crc_t c, hsf_word_t w);
    hsf_crc_t r;
    logic fb;
    r = c;
    for (int i = 0; i < 10; i++) begin
      fb = r[17] ^ w[i];
      r = {r[16:0], 1'b0};
      if (fb) begin
        r = r ^ `HSF_CRC_POLY;
      end
    end
    return r;
  endfunction

  // Word with b9 forced to the inverse of b8
  function automatic hsf_word_t prot(logic [8:0] v);
    return {~v[8], v};
  endfunction

  // Timing code flag word: field, vblank, end flag and protection
  function automatic hsf_word_t trs_flag(logic f, logic v, logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction

  // Flip the 18-bit code so that code bit 0 is the shift MSB
  function automatic hsf_crc_t crc_rev(hsf_crc_t c);
    hsf_crc_t r;
    for (int i = 0; i < 18; i++) begin
      r[i] = c[17 - i];
    end
    return r;
  endfunction

  hsf_phase_t ph_q, ph_d;
  logic [10:0] idx_q, idx_d;
  hsf_crc_t ycrc_q, ycrc_d, ccrc_q, ccrc_d;
  hsf_word_t y_w, c_w;
  logic take, fill_valid, fill_ready;
  hsf_crc_t yr, cr;

  // Word builder: one luma and one chroma word per beat
  always_comb begin
    ph_d = ph_q;
    idx_d = idx_q;
    ycrc_d = ycrc_q;
    ccrc_d = ccrc_q;
    yr = crc_rev(ycrc_q);
    cr = crc_rev(ccrc_q);
    y_w = LUMA_IN;
    c_w = CHROMA_IN;
    unique case (ph_q)
      HSF_ST_ACTIVE: begin
        y_w = LUMA_IN;
        c_w = CHROMA_IN;
      end
      HSF_ST_EAV, HSF_ST_SAV: begin
        unique case (idx_q[1:0])
          2'h0: y_w = `HSF_TRS_ONES;
          2'h1, 2'h2: y_w = `HSF_TRS_ZERO;
          default: y_w = trs_flag(FLAGS_IN[1], FLAGS_IN[0],
                                  ph_q == HSF_ST_EAV);
        endcase
        c_w = y_w;
      end
      HSF_ST_LN0: begin
        y_w = prot({LINE_IN[6:0], 2'b00});
        c_w = y_w;
      end
      HSF_ST_LN1: begin
        y_w = prot({3'b000, LINE_IN[10:7], 2'b00});
        c_w = y_w;
      end
      HSF_ST_CRC0: begin
        y_w = prot(yr[8:0]);
        c_w = prot(cr[8:0]);
      end
      HSF_ST_CRC1: begin
        y_w = prot(yr[17:9]);
        c_w = prot(cr[17:9]);
      end
      HSF_ST_HINT: begin
        y_w = `HSF_LUMA_BLANK;
        c_w = `HSF_CHROMA_BLANK;
      end
    endcase
    if (take) begin
      // Both streams keep their own code
      if (ph_q != HSF_ST_CRC0 && ph_q != HSF_ST_CRC1 &&
          ph_q != HSF_ST_HINT && ph_q != HSF_ST_SAV) begin
        ycrc_d = crc_step(ycrc_q, y_w);
        ccrc_d = crc_step(ccrc_q, c_w);
      end
      idx_d = idx_q + 11'h001;
      unique case (ph_q)
        HSF_ST_ACTIVE: if (idx_q == 11'(ACTIVE_LUMA - 1)) begin
          ph_d = HSF_ST_EAV;
          idx_d = '0;
        end
        HSF_ST_EAV: if (idx_q == 11'h003) ph_d = HSF_ST_LN0;
        HSF_ST_LN0: ph_d = HSF_ST_LN1;
        HSF_ST_LN1: ph_d = HSF_ST_CRC0;
        HSF_ST_CRC0: ph_d = HSF_ST_CRC1;
        HSF_ST_CRC1: begin
          ph_d = HSF_ST_HINT;
          idx_d = '0;
        end
        HSF_ST_HINT: if (idx_q == 11'(HINT_WORDS - 1)) begin
          ph_d = HSF_ST_SAV;
          idx_d = '0;
        end
        HSF_ST_SAV: if (idx_q == 11'h003) begin
          ph_d = HSF_ST_ACTIVE;
          idx_d = '0;
          ycrc_d = '0;
          ccrc_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ph_q <= HSF_ST_SAV;
      idx_q <= '0;
      ycrc_q <= '0;
      ccrc_q <= '0;
    end else begin
      ph_q <= ph_d;
      idx_q <= idx_d;
      ycrc_q <= ycrc_d;
      ccrc_q <= ccrc_d;
    end
  end

  // Mux order blue, luma, red, luma; chroma carries blue then red
  logic [1:0] beat_q, beat_d;
  hsf_word_t y_hold_q, y_hold_d, mux_w;
  logic src_ready_q, src_ready_d;
  always_comb begin
    beat_d = beat_q;
    y_hold_d = y_hold_q;
    fill_valid = 1'b1;
    mux_w = (beat_q[0]) ? y_hold_q : c_w;
    take = fill_ready && !beat_q[0];
    if (fill_ready) begin
      beat_d = beat_q + 2'h1;
      if (!beat_q[0]) begin
        y_hold_d = y_w;
      end
    end
    src_ready_d = fill_ready && !beat_d[0] && ph_d == HSF_ST_ACTIVE;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      beat_q <= 2'h0;
      y_hold_q <= '0;
      src_ready_q <= 1'b0;
    end else begin
      beat_q <= beat_d;
      y_hold_q <= y_hold_d;
      src_ready_q <= src_ready_d;
    end
  end

  // Buffer so a stalled serializer loses no word
  logic buf_valid, buf_ready;
  hsf_word_t buf_word;
  hsf_skid #(
    .WIDTH(`HSF_WORD_W)
  ) u_buf (
    .clk(CLK_SYS),
    .rst(RESET),
    .in_valid(fill_valid),
    .in_ready(fill_ready),
    .in_data(mux_w),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_word)
  );

  // Serializer, LSB first, one bit per clock
  hsf_word_t sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic run_q, run_d;
  logic [8:0] scr_q, scr_d;
  logic nrzi_q, nrzi_d, en_q, en_d;
  logic sbit, din;
  always_comb begin
    sh_d = sh_q;
    bit_d = bit_q;
    run_d = run_q;
    scr_d = scr_q;
    nrzi_d = nrzi_q;
    en_d = 1'b0;
    din = sh_q[0];
    sbit = din ^ scr_q[3] ^ scr_q[8];
    buf_ready = !run_q || bit_q == 4'h9;
    if (run_q) begin
      sh_d = {1'b0, sh_q[9:1]};
      scr_d = {scr_q[7:0], sbit};
      nrzi_d = nrzi_q ^ sbit;
      en_d = 1'b1;
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h9) begin
        run_d = 1'b0;
        bit_d = '0;
      end
    end
    if (buf_ready && buf_valid) begin
      sh_d = buf_word;
      run_d = 1'b1;
      bit_d = '0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      sh_q <= '0;
      bit_q <= '0;
      run_q <= 1'b0;
      scr_q <= '0;
      nrzi_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      run_q <= run_d;
      scr_q <= scr_d;
      nrzi_q <= nrzi_d;
      en_q <= en_d;
    end
  end

  assign SER_OUT = nrzi_q;
  assign SER_BIT_EN = en_q;
  assign SRC_READY = src_ready_q;

  // NRZI line toggles exactly when the scrambled bit is one
  a_nrzi_toggle: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    run_q |=> (nrzi_q == ($past(nrzi_q) ^ $past(sbit))))
    else $error("NRZI level does not follow scrambled bit");

  // Line number words follow the end code
  a_eav_lnum: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take && ph_q == HSF_ST_EAV && idx_q == 11'h003) |=> ph_q == HSF_ST_LN0)
    else $error("Line number does not follow end code");

  // Check words follow the line number words
  a_lnum_crc: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take && ph_q == HSF_ST_LN1) |=> ph_q == HSF_ST_CRC0)
    else $error("Check words misplaced");

  // Check codes clear at start of line
  a_crc_clear: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (take && ph_q == HSF_ST_SAV && idx_q == 11'h003) |=>
      (ycrc_q == '0 && ccrc_q == '0))
    else $error("Check code not cleared");

  // Upper line number word: fixed one in b9, reserved zeros, bits 7-10
  a_ln_prot: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (ph_q == HSF_ST_LN1) |-> (y_w == {1'b1, 3'b000, LINE_IN[10:7], 2'b00}))
    else $error("Line number word format wrong");

  // Blanking fill levels
  a_blank_lvl: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (ph_q == HSF_ST_HINT) |-> (y_w == 10'h040 && c_w == 10'h200))
    else $error("Blanking level wrong");

  // Ten bits go out per word
  a_word_bits: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (run_q && bit_q == 4'h0) |-> ##9 (run_q && bit_q == 4'h9))
    else $error("Word is not ten bits long");

  // Luma check code holds through the first check word slot
  a_crc_hold: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (ph_q == HSF_ST_CRC0) |=> $stable(ycrc_q))
    else $error("Check code moved during check words");
endmodule
`default_nettype wire

// ### testbench/hsf_rx_model.sv
// Far-end receiver model: NRZI decode, descramble, rebuild words
`timescale 1ns/10ps
`default_nettype none
module hsf_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial line from the formatter
  input wire logic ser,
  input wire logic bit_en,
  // Recovered words
  output logic word_valid,
  output hsf_pkg::hsf_word_t word
);
  import hsf_pkg::*;
  logic lvl_q;
  logic [8:0] sh_q;
  int cnt_q;
  hsf_word_t acc_q;
  hsf_word_t acc;
  logic s;
  // Self-synchronising descrambler; word lock relies on reset alignment
  always @(posedge clk) begin
    s = ser ^ lvl_q;
    acc = {s ^ sh_q[3] ^ sh_q[8], acc_q[9:1]};
    word_valid <= 1'b0;
    if (rst) begin
      lvl_q <= 1'b0;
      sh_q <= 9'h000;
      cnt_q <= 0;
    end else if (bit_en) begin
      lvl_q <= ser;
      sh_q <= {sh_q[7:0], s};
      acc_q <= acc;
      cnt_q <= (cnt_q == 9) ? 0 : cnt_q + 1;
      if (cnt_q == 9) begin
        word <= acc;
        word_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/hdtv_serial_stream_formatter_test.sv
// Self-checking bench for the serial stream formatter
`timescale 1ns/10ps
`default_nettype none
module hdtv_serial_stream_formatter_test;
  import hsf_pkg::*;
  localparam int NA = 8;
  localparam int NH = 4;
  localparam int WPL = 2 * (NA + NH + 12);
  logic clk_sys;
  logic reset;
  hsf_word_t luma_in;
  hsf_word_t chroma_in;
  hsf_word_t rx_word;
  logic [1:0] flags_in;
  hsf_line_t line_in;
  logic src_ready;
  logic ser_out;
  logic ser_bit_en;
  logic rx_valid;
  int err_total;
  int n_checks;
  int beat;
  hsf_word_t rxq[$];
  hsf_word_t expq[$];
  int catq[$];
  hsf_crc_t cc;
  hsf_crc_t yc;

  hsf_formatter #(.ACTIVE_LUMA(NA), .HINT_WORDS(NH)) DUT (
    .CLK_SYS(clk_sys),
    .RESET(reset),
    .LUMA_IN(luma_in),
    .CHROMA_IN(chroma_in),
    .FLAGS_IN(flags_in),
    .LINE_IN(line_in),
    .SRC_READY(src_ready),
    .SER_OUT(ser_out),
    .SER_BIT_EN(ser_bit_en)
  );

  hsf_rx_model rx (
    .clk(clk_sys),
    .rst(reset),
    .ser(ser_out),
    .bit_en(ser_bit_en),
    .word_valid(rx_valid),
    .word(rx_word)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic hsf_word_t lw(int k);
    return hsf_word_t'(10'h100 + 3 * k);
  endfunction

  function automatic hsf_word_t cw(int k);
    return hsf_word_t'(10'h080 + 5 * k);
  endfunction

  // Protected flag word: field, vblank, end flag and parity bits
  function automatic hsf_word_t trs(logic [1:0] f, logic h);
    return {1'b1, f[1], f[0], h, f[0] ^ h, f[1] ^ h, f[1] ^ f[0],
            f[1] ^ f[0] ^ h, 2'b00};
  endfunction

  // Reflected form of x^18+x^5+x^4+1, word fed LSB first
  function automatic hsf_crc_t crc_upd(hsf_crc_t c, hsf_word_t w);
    logic fb;
    for (int i = 0; i < 10; i++) begin
      fb = w[i] ^ c[0];
      c = (c >> 1) ^ (fb ? 18'h23000 : 18'h00000);
    end
    return c;
  endfunction

  // Source: each ready pulse comes one word slot ahead of the take,
  // so the pair shown after pulse k is the one consumed as sample k
  always @(posedge clk_sys) begin
    automatic logic take = (src_ready === 1'b1) && (reset === 1'b0);
    #2;
    if (reset) beat = -1;
    else if (take) beat = beat + 1;
    luma_in = lw(beat);
    chroma_in = cw(beat);
  end

  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_word);
  end

  task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic add(hsf_word_t c, hsf_word_t y, int cat);
    expq.push_back(c);
    expq.push_back(y);
    catq.push_back(cat);
    catq.push_back(cat);
    cc = crc_upd(cc, c);
    yc = crc_upd(yc, y);
  endtask

  task automatic build_line(int n, logic [1:0] fl, hsf_line_t ln);
    hsf_crc_t c;
    hsf_crc_t y;
    add(10'h3ff, 10'h3ff, 0);
    add(10'h000, 10'h000, 0);
    add(10'h000, 10'h000, 0);
    add(trs(fl, 1'b0), trs(fl, 1'b0), 0);
    cc = '0;
    yc = '0;
    for (int k = 0; k < NA; k++) add(cw(n * NA + k), lw(n * NA + k), 1);
    add(10'h3ff, 10'h3ff, 0);
    add(10'h000, 10'h000, 0);
    add(10'h000, 10'h000, 0);
    add(trs(fl, 1'b1), trs(fl, 1'b1), 0);
    add({~ln[6], ln[6:0], 2'b00}, {~ln[6], ln[6:0], 2'b00}, 2);
    add({1'b1, 3'b000, ln[10:7], 2'b00}, {1'b1, 3'b000, ln[10:7], 2'b00}, 2);
    c = cc;
    y = yc;
    add({~c[8], c[8:0]}, {~y[8], y[8:0]}, 3);
    add({~c[17], c[17:9]}, {~y[17], y[17:9]}, 3);
    for (int k = 0; k < NH; k++) add(10'h200, 10'h040, 4);
  endtask

  // Reset for eight cycles, stream nl lines, compare every word
  task automatic run_lines(logic [1:0] fl, hsf_line_t ln, int nl);
    @(posedge clk_sys);
    #2;
    reset = 1'b1;
    flags_in = fl;
    line_in = ln;
    repeat (8) @(posedge clk_sys);
    #2;
    rxq.delete();
    expq.delete();
    catq.delete();
    for (int n = 0; n < nl; n++) build_line(n, fl, ln);
    reset = 1'b0;
    for (int i = 0; i < 2000 * nl && rxq.size() < WPL * nl; i++)
      @(posedge clk_sys);
    check("word count", 18'(rxq.size() >= WPL * nl), 18'h1);
    if (rxq.size() < WPL * nl) complete_run();
    for (int i = 0; i < expq.size(); i++) begin
      case (catq[i])
        0: check("timing word", rxq[i], expq[i]);
        1: check("active word", rxq[i], expq[i]);
        2: check("line number", rxq[i], expq[i]);
        3: check("check word", rxq[i], expq[i]);
        default: check("blank word", rxq[i], expq[i]);
      endcase
    end
  endtask

  task automatic scen_reset();
    repeat (3) @(posedge clk_sys);
    #2;
    check("reset outputs", {src_ready, ser_out, ser_bit_en}, 18'h0);
  endtask

  task automatic scen_basic();
    run_lines(2'b00, 11'h5a3, 2);
  endtask

  task automatic scen_limits();
    run_lines(2'b11, 11'h7ff, 1);
  endtask

  task automatic scen_flags();
    run_lines(2'b10, 11'h001, 1);
    run_lines(2'b01, 11'h400, 1);
  endtask

  // Reset lands in mid-line; the next run must restart cleanly
  task automatic scen_mid_reset();
    repeat (150) @(posedge clk_sys);
    #2;
    reset = 1'b1;
    @(posedge clk_sys);
    #2;
    check("mid reset", {src_ready, ser_bit_en}, 18'h0);
    run_lines(2'b01, 11'h2aa, 1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    flags_in = 2'b00;
    line_in = 11'h000;
    luma_in = 10'h000;
    chroma_in = 10'h000;
    err_total = 0;
    n_checks = 0;
    beat = 0;
    scen_reset();
    scen_basic();
    scen_limits();
    scen_flags();
    scen_mid_reset();
    complete_run();
  end
endmodule
`default_nettype wire
